// *** amt_pkg.sv ***
// package: register map and constants of the channel minimum tracker
package amt_pkg;
  // ==========================================================================
  // register index (printed offsets are not multiples of four)
  localparam logic [7:0] MIN_CH2_HIGH_IDX = 8'h85;
  localparam logic [7:0] MIN_CH3_LOW_IDX = 8'h86;
  localparam logic [7:0] MIN_CH3_HIGH_IDX = 8'h87;
  localparam logic [7:0] MIN_CH4_LOW_IDX = 8'h88;
  localparam logic [7:0] MIN_CH4_HIGH_IDX = 8'h89;
  localparam logic [7:0] MIN_CH5_LOW_IDX = 8'h8a;
  localparam logic [7:0] MIN_CH5_HIGH_IDX = 8'h8b;
  localparam logic [7:0] MIN_CH6_LOW_IDX = 8'h8c;
  // ==========================================================================
  // layout and reset
  localparam int ADDR_W = 12;
  localparam int CODE_W = 16;
  localparam int FIRST_CH = 2;
  localparam int LAST_CH = 6;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam logic [15:0] MIN_RESET = 16'hffff;
  localparam logic [7:0] BYTE_RESET = 8'hff;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : amt_pkg

// *** amt_min_tracker.sv ***
// module: per-channel minimum code tracker with read-to-restart registers
// Function
// - keep lowest conversion code per channel, for channels 2 to 6 only
// - each read restarts that register's tracking window
// - read returns value then reloads 0xFF
// - reset leaves every byte at 0xFF
// - low byte even, high byte odd register index
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module amt_min_tracker (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [amt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // conversion results from the engine, same clock
  input wire logic result_valid,
  input wire logic [amt_pkg::CH_W-1:0] result_ch,
  input wire logic [amt_pkg::CODE_W-1:0] result_code
);
  import amt_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [NUM_CH-1:0][7:0] lo;
    logic [NUM_CH-1:0][7:0] hi;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } amt_state_s;

  amt_state_s st_q;
  amt_state_s st_d;

  // ==========================================================================
  // address decode: byte address is four times the register index
  function automatic logic [8:0] amt_decode(
    input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    logic [8:0] res;
    // only the low eight index bits are decoded; upper bits must be zero
    idx = a[9:2];
    res = 9'h000;
    if (a[1:0] != 2'b00 || a[ADDR_W-1:10] != 2'b00) begin
      res = 9'h000;
    end else if (idx == MIN_CH2_HIGH_IDX) begin
      res = {1'b1, 1'b1, 4'd2, 3'd0};
    end else if (idx == MIN_CH3_LOW_IDX) begin
      res = {1'b1, 1'b0, 4'd3, 3'd0};
    end else if (idx == MIN_CH3_HIGH_IDX) begin
      res = {1'b1, 1'b1, 4'd3, 3'd0};
    end else if (idx == MIN_CH4_LOW_IDX) begin
      res = {1'b1, 1'b0, 4'd4, 3'd0};
    end else if (idx == MIN_CH4_HIGH_IDX) begin
      res = {1'b1, 1'b1, 4'd4, 3'd0};
    end else if (idx == MIN_CH5_LOW_IDX) begin
      res = {1'b1, 1'b0, 4'd5, 3'd0};
    end else if (idx == MIN_CH5_HIGH_IDX) begin
      res = {1'b1, 1'b1, 4'd5, 3'd0};
    end else if (idx == MIN_CH6_LOW_IDX) begin
      res = {1'b1, 1'b0, 4'd6, 3'd0};
    end
    return res;
  endfunction : amt_decode

  // ==========================================================================
  // next state
  logic [8:0] dec;
  logic hit;
  logic sel_hi;
  logic [CH_W-1:0] sel_ch;
  logic setup;
  logic [15:0] cur;

  always_comb begin
    st_d = st_q;
    dec = amt_decode(paddr);
    hit = dec[8];
    sel_hi = dec[7];
    sel_ch = dec[5:3];
    // answer one cycle after setup: no wait state, registered data
    setup = psel && !penable;
    st_d.ready = setup;
    st_d.err = 1'b0;
    cur = 16'h0000;
    if (setup) begin
      st_d.err = !hit;
      st_d.rdata = READ_ZERO;
      if (hit && !pwrite) begin
        st_d.rdata = {24'h00_0000,
          sel_hi ? st_q.hi[sel_ch] : st_q.lo[sel_ch]};
      end
    end
    // writes to mapped registers complete but store nothing
    // track minimum; a new result below the restarted value beats a restart in the same cycle
    if (result_valid && result_ch >= CH_W'(FIRST_CH)
        && result_ch <= CH_W'(LAST_CH)) begin
      cur = {st_q.hi[result_ch], st_q.lo[result_ch]};
    end
    // restart on the completing read edge, reload all ones
    if (psel && penable && st_q.ready && !pwrite && hit) begin
      if (sel_hi) begin
        st_d.hi[sel_ch] = BYTE_RESET;
      end else begin
        st_d.lo[sel_ch] = BYTE_RESET;
      end
    end
    // a fresh result in the restart cycle wins only if below the value left by the restart (reloaded byte at 0xFF)
    if (result_valid && result_ch >= CH_W'(FIRST_CH)
        && result_ch <= CH_W'(LAST_CH)) begin
      if (result_code < cur) begin
        st_d.hi[result_ch] = result_code[15:8];
        st_d.lo[result_ch] = result_code[7:0];
      end else if (result_code < {st_d.hi[result_ch],
                                  st_d.lo[result_ch]}) begin
        st_d.hi[result_ch] = result_code[15:8];
        st_d.lo[result_ch] = result_code[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.lo <= {NUM_CH{BYTE_RESET}};
      st_q.hi <= {NUM_CH{BYTE_RESET}};
      st_q.rdata <= READ_ZERO;
      st_q.ready <= 1'b0;
      st_q.err <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.err;

  // ==========================================================================
  // checks: reload on read, a same-cycle result on the channel is excluded
  read_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && paddr == 12'h214
     && !(result_valid && result_ch == 3'd2))
    |=> st_q.hi[2] == BYTE_RESET)
    else $error("read did not reload all ones");
  reload_c3_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && paddr == 12'h218
     && !(result_valid && result_ch == 3'd3))
    |=> st_q.lo[3] == BYTE_RESET)
    else $error("read did not reload all ones");
  reload_c3_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && paddr == 12'h21c
     && !(result_valid && result_ch == 3'd3))
    |=> st_q.hi[3] == BYTE_RESET)
    else $error("read did not reload all ones");
  reload_c4_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && paddr == 12'h220
     && !(result_valid && result_ch == 3'd4))
    |=> st_q.lo[4] == BYTE_RESET)
    else $error("read did not reload all ones");
  reload_c4_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && paddr == 12'h224
     && !(result_valid && result_ch == 3'd4))
    |=> st_q.hi[4] == BYTE_RESET)
    else $error("read did not reload all ones");
  reload_c5_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && paddr == 12'h228
     && !(result_valid && result_ch == 3'd5))
    |=> st_q.lo[5] == BYTE_RESET)
    else $error("read did not reload all ones");
  reload_c5_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && paddr == 12'h22c
     && !(result_valid && result_ch == 3'd5))
    |=> st_q.hi[5] == BYTE_RESET)
    else $error("read did not reload all ones");
  reload_c6_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && paddr == 12'h230
     && !(result_valid && result_ch == 3'd6))
    |=> st_q.lo[6] == BYTE_RESET)
    else $error("read did not reload all ones");
  // ==========================================================================
  // checks: tracking
  min_update_a: assert property (@(posedge pclk) disable iff (!presetn)
    (result_valid && result_ch == 3'd4 &&
     result_code < {st_q.hi[4], st_q.lo[4]})
    |=> {st_q.hi[4], st_q.lo[4]} == $past(result_code))
    else $error("smaller result not stored");
  min_c2_a: assert property (@(posedge pclk) disable iff (!presetn)
    (result_valid && result_ch == 3'd2 &&
     result_code < {st_q.hi[2], st_q.lo[2]})
    |=> {st_q.hi[2], st_q.lo[2]} == $past(result_code))
    else $error("smaller result not stored");
  min_c3_a: assert property (@(posedge pclk) disable iff (!presetn)
    (result_valid && result_ch == 3'd3 &&
     result_code < {st_q.hi[3], st_q.lo[3]})
    |=> {st_q.hi[3], st_q.lo[3]} == $past(result_code))
    else $error("smaller result not stored");
  min_c5_a: assert property (@(posedge pclk) disable iff (!presetn)
    (result_valid && result_ch == 3'd5 &&
     result_code < {st_q.hi[5], st_q.lo[5]})
    |=> {st_q.hi[5], st_q.lo[5]} == $past(result_code))
    else $error("smaller result not stored");
  min_c6_a: assert property (@(posedge pclk) disable iff (!presetn)
    (result_valid && result_ch == 3'd6 &&
     result_code < {st_q.hi[6], st_q.lo[6]})
    |=> {st_q.hi[6], st_q.lo[6]} == $past(result_code))
    else $error("smaller result not stored");
  no_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!(psel && penable && pready && !pwrite))
    |=> {st_q.hi[5], st_q.lo[5]} <= $past({st_q.hi[5], st_q.lo[5]}))
    else $error("minimum grew without a read");
  no_raise_c2_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!(psel && penable && pready && !pwrite))
    |=> {st_q.hi[2], st_q.lo[2]} <= $past({st_q.hi[2], st_q.lo[2]}))
    else $error("minimum grew without a read");
  no_raise_c3_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!(psel && penable && pready && !pwrite))
    |=> {st_q.hi[3], st_q.lo[3]} <= $past({st_q.hi[3], st_q.lo[3]}))
    else $error("minimum grew without a read");
  no_raise_c4_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!(psel && penable && pready && !pwrite))
    |=> {st_q.hi[4], st_q.lo[4]} <= $past({st_q.hi[4], st_q.lo[4]}))
    else $error("minimum grew without a read");
  no_raise_c6_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!(psel && penable && pready && !pwrite))
    |=> {st_q.hi[6], st_q.lo[6]} <= $past({st_q.hi[6], st_q.lo[6]}))
    else $error("minimum grew without a read");
  untracked_ch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (result_valid && result_ch == 3'd7
     && !(psel && penable && pready))
    |=> $stable({st_q.hi[6], st_q.lo[6]}))
    else $error("untracked channel changed a minimum");
  write_inert_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && !result_valid)
    |=> $stable({st_q.hi, st_q.lo}))
    else $error("write changed a minimum");
  // ==========================================================================
  // checks: reset values
  reset_value_a: assert property (@(posedge pclk)
    $rose(presetn) |-> st_q.lo[3] == BYTE_RESET)
    else $error("reset value not all ones");
  reset_c2_hi_a: assert property (@(posedge pclk)
    $rose(presetn) |-> st_q.hi[2] == BYTE_RESET)
    else $error("reset value not all ones");
  reset_c3_hi_a: assert property (@(posedge pclk)
    $rose(presetn) |-> st_q.hi[3] == BYTE_RESET)
    else $error("reset value not all ones");
  reset_c4_lo_a: assert property (@(posedge pclk)
    $rose(presetn) |-> st_q.lo[4] == BYTE_RESET)
    else $error("reset value not all ones");
  reset_c4_hi_a: assert property (@(posedge pclk)
    $rose(presetn) |-> st_q.hi[4] == BYTE_RESET)
    else $error("reset value not all ones");
  reset_c5_lo_a: assert property (@(posedge pclk)
    $rose(presetn) |-> st_q.lo[5] == BYTE_RESET)
    else $error("reset value not all ones");
  reset_c5_hi_a: assert property (@(posedge pclk)
    $rose(presetn) |-> st_q.hi[5] == BYTE_RESET)
    else $error("reset value not all ones");
  reset_c6_lo_a: assert property (@(posedge pclk)
    $rose(presetn) |-> st_q.lo[6] == BYTE_RESET)
    else $error("reset value not all ones");
  // ==========================================================================
  // checks: map and bus answer
  map_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == 12'h218) |=> !pslverr)
    else $error("mapped address refused");
  map_c2_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == 12'h214) |=> !pslverr)
    else $error("mapped address refused");
  map_c3_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == 12'h21c) |=> !pslverr)
    else $error("mapped address refused");
  map_c4_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == 12'h220) |=> !pslverr)
    else $error("mapped address refused");
  map_c4_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == 12'h224) |=> !pslverr)
    else $error("mapped address refused");
  map_c5_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == 12'h228) |=> !pslverr)
    else $error("mapped address refused");
  map_c5_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == 12'h22c) |=> !pslverr)
    else $error("mapped address refused");
  map_c6_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == 12'h230) |=> !pslverr)
    else $error("mapped address refused");
  unmapped_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == 12'h300)
    |=> pslverr && prdata == READ_ZERO)
    else $error("unmapped address not refused");
  ready_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("no answer after setup");
  ready_single_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && !penable) |=> !pready)
    else $error("answer without setup");
  err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error flag without answer");
endmodule : amt_min_tracker
`default_nettype wire

// *** tb_amt_min_tracker.sv ***
// testbench: minimum tracker reads, restart, write and unmapped checks
`timescale 1ns/1ps
`default_nettype none
module tb_amt_min_tracker;
  import amt_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, result_valid = 0;
  logic [2:0] result_ch = 0;
  logic [15:0] result_code = 0;
  logic [7:0] idx_tab [8] = '{MIN_CH2_HIGH_IDX, MIN_CH3_LOW_IDX,
    MIN_CH3_HIGH_IDX, MIN_CH4_LOW_IDX, MIN_CH4_HIGH_IDX, MIN_CH5_LOW_IDX,
    MIN_CH5_HIGH_IDX, MIN_CH6_LOW_IDX};
  int err_count = 0, samples_checked = 0;
  // ==========================================================================
  // clock, device
  always #25 pclk = ~pclk;
  amt_min_tracker dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .result_valid(result_valid), .result_ch(result_ch),
    .result_code(result_code));
  // ==========================================================================
  // tasks
  task automatic conclude();
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // request held until pready is sampled high; answer taken at that edge
  task automatic apb(input logic w, input logic [7:0] ix,
                     input logic [31:0] wd);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic res(input logic [2:0] ch, input logic [15:0] code);
    result_valid <= 1;
    result_ch <= ch;
    result_code <= code;
    @(posedge pclk);
    result_valid <= 0;
    @(posedge pclk);
  endtask : res
  // entry i maps to channel (i+5)/2, high byte at even i
  function automatic logic [7:0] exp_min(input int i);
    logic [7:0] ch;
    ch = 8'((i + 5) / 2);
    return (i % 2 == 0) ? 8'h30 + ch : 8'h50 + ch;
  endfunction : exp_min
  // ==========================================================================
  // sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      apb(0, idx_tab[i], 0);
      chk(rd, 32'h0000_00ff);
      chk({31'b0, er}, 0);
    end
    for (int c = 2; c <= 7; c++) begin
      res(3'(c), {8'h40 + 8'(c), 8'h20 + 8'(c)});
      res(3'(c), {8'h30 + 8'(c), 8'h50 + 8'(c)});
      res(3'(c), 16'h7001);
    end
    res(3'd7, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      apb(0, idx_tab[i], 0);
      chk(rd, {24'h0, exp_min(i)});
    end
    for (int i = 0; i < 8; i++) begin
      apb(0, idx_tab[i], 0);
      chk(rd, 32'h0000_00ff);
    end
    res(3'd3, 16'h1122);
    apb(1, MIN_CH3_LOW_IDX, 32'h0000_0000);
    apb(1, MIN_CH3_HIGH_IDX, 32'h0000_0000);
    apb(0, MIN_CH3_LOW_IDX, 0);
    chk(rd, 32'h0000_0022);
    apb(0, MIN_CH3_HIGH_IDX, 0);
    chk(rd, 32'h0000_0011);
    apb(0, 8'hc0, 0);
    chk({31'b0, er}, 1);
    chk(rd, 32'h0000_0000);
    conclude();
  end
endmodule : tb_amt_min_tracker
`default_nettype wire
